/* rtl/rgc_pkg.sv */
package rgc_pkg;
  // register byte offsets
  localparam logic [7:0] GLOBAL_COMMAND_OFS = 8'h18;
  localparam logic [7:0] GLOBAL_STATUS_OFS = 8'h1c;
  localparam logic [7:0] ROOT_TABLE_ADDRESS_OFS = 8'h20;
  localparam logic [7:0] FAULT_LOG_ADDRESS_OFS = 8'h28;
  localparam logic [7:0] ACTIVE_ROOT_OFS = 8'h30;
  localparam logic [7:0] ACTIVE_FAULT_OFS = 8'h34;
  // field positions, shared by command and status words
  localparam int DMA_REMAP_ON_BIT = 31;
  localparam int LOAD_ROOT_POINTER_BIT = 30;
  localparam int LOAD_FAULT_LOG_POINTER_BIT = 29;
  // reset value and command-read filler
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [31:0] UNDEFINED_READ = 32'h0000_0000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DRAIN = 2'b10
  } rgc_state_t;
endpackage

/* rtl/rgc_drain.sv */
`timescale 1ns/10ps
module rgc_drain #(
  parameter int CNT_W = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic done,
  output logic idle
);
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;

  generate
    if (CNT_W < 1 || CNT_W > 16) begin : g_bad
      $error("rgc_drain: CNT_W out of range");
    end
  endgenerate

  // no transaction in flight once this cycle's events settle
  always_comb begin
    count_nxt = count_r + CNT_W'(start) - CNT_W'(done);
    idle = !start && (count_r == '0 || (count_r == CNT_W'(1) && done));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end
endmodule

/* rtl/rgc_top.sv */
// Notes on behaviour
// - bit 31 write requests remapping on/off
// - remap-on status shows completed switch
// - switch only at a transaction boundary
// - drain in-flight requests before switch completes
// - command bits read back undefined
// - bit 30 latches root table address
// - root-pointer status shows load complete
// - writing zero to load bits does nothing
// - bit 29 latches fault-log pointer, if supported
// - fault-pointer status shows load complete
// - fault pointer reload accepted while remapping
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
module rgc_top #(
  parameter int DRAIN_EN = 1,
  parameter int ADV_LOG_EN = 1,
  parameter int CNT_W = 6
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic DMA_START,
  input wire logic DMA_DONE,
  output logic DMA_HOLD,
  output logic REMAP_ACTIVE,
  output logic [31:0] ROOT_POINTER,
  output logic [31:0] FAULT_LOG_POINTER
);
  rgc_pkg::rgc_state_t state_r;
  rgc_pkg::rgc_state_t state_nxt;
  logic target_r;
  logic target_nxt;
  logic remap_r;
  logic remap_nxt;
  logic hold_r;
  logic hold_nxt;
  logic root_pend_r;
  logic root_pend_nxt;
  logic root_sts_r;
  logic root_sts_nxt;
  logic fault_pend_r;
  logic fault_pend_nxt;
  logic fault_sts_r;
  logic fault_sts_nxt;
  logic [31:0] root_addr_r;
  logic [31:0] root_addr_nxt;
  logic [31:0] fault_addr_r;
  logic [31:0] fault_addr_nxt;
  logic [31:0] active_root_r;
  logic [31:0] active_root_nxt;
  logic [31:0] active_fault_r;
  logic [31:0] active_fault_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic wr_cmd;
  logic drain_idle;

  generate
    if (DRAIN_EN < 0 || DRAIN_EN > 1 || ADV_LOG_EN < 0 || ADV_LOG_EN > 1) begin : g_bad
      $error("rgc_top: DRAIN_EN and ADV_LOG_EN must be 0 or 1");
    end
  endgenerate

  rgc_drain #(
    .CNT_W(CNT_W)
  ) u_drain (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .start(DMA_START),
    .done(DMA_DONE),
    .idle(drain_idle)
  );

  assign wr_cmd = REG_WR && REG_ADDR == rgc_pkg::GLOBAL_COMMAND_OFS;

  // remap switch sequencing
  always_comb begin
    state_nxt = state_r;
    target_nxt = target_r;
    remap_nxt = remap_r;
    hold_nxt = hold_r;
    if (wr_cmd) begin
      target_nxt = REG_WDATA[rgc_pkg::DMA_REMAP_ON_BIT];
    end
    case (state_r)
      rgc_pkg::ST_IDLE: begin
        if (target_r != remap_r) begin
          state_nxt = rgc_pkg::ST_DRAIN;
          hold_nxt = (DRAIN_EN == 1);
        end
      end
      rgc_pkg::ST_DRAIN: begin
        // switch only with nothing in flight
        if (drain_idle) begin
          remap_nxt = target_r;
          hold_nxt = 1'b0;
          state_nxt = rgc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = rgc_pkg::ST_IDLE;
        hold_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      state_r <= rgc_pkg::ST_IDLE;
      target_r <= 1'b0;
      remap_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      target_r <= target_nxt;
      remap_r <= remap_nxt;
      hold_r <= hold_nxt;
    end
  end

  // pointer registers and pointer loads
  always_comb begin
    root_addr_nxt = root_addr_r;
    fault_addr_nxt = fault_addr_r;
    active_root_nxt = active_root_r;
    active_fault_nxt = active_fault_r;
    root_pend_nxt = root_pend_r;
    root_sts_nxt = root_sts_r;
    fault_pend_nxt = fault_pend_r;
    fault_sts_nxt = fault_sts_r;
    if (REG_WR && REG_ADDR == rgc_pkg::ROOT_TABLE_ADDRESS_OFS) begin
      root_addr_nxt = REG_WDATA;
    end
    if (REG_WR && REG_ADDR == rgc_pkg::FAULT_LOG_ADDRESS_OFS) begin
      fault_addr_nxt = REG_WDATA;
    end
    if (root_pend_r) begin
      active_root_nxt = root_addr_r;
      root_pend_nxt = 1'b0;
      root_sts_nxt = 1'b1;
    end
    if (fault_pend_r) begin
      active_fault_nxt = fault_addr_r;
      fault_pend_nxt = 1'b0;
      fault_sts_nxt = 1'b1;
    end
    // new command wins over completion; zero bits ignored
    if (wr_cmd && REG_WDATA[rgc_pkg::LOAD_ROOT_POINTER_BIT]) begin
      root_pend_nxt = 1'b1;
      root_sts_nxt = 1'b0;
    end
    if (wr_cmd && REG_WDATA[rgc_pkg::LOAD_FAULT_LOG_POINTER_BIT] && ADV_LOG_EN == 1) begin
      fault_pend_nxt = 1'b1;
      fault_sts_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      root_addr_r <= rgc_pkg::WORD_RESET;
      fault_addr_r <= rgc_pkg::WORD_RESET;
      active_root_r <= rgc_pkg::WORD_RESET;
      active_fault_r <= rgc_pkg::WORD_RESET;
      root_pend_r <= 1'b0;
      root_sts_r <= 1'b0;
      fault_pend_r <= 1'b0;
      fault_sts_r <= 1'b0;
    end else begin
      root_addr_r <= root_addr_nxt;
      fault_addr_r <= fault_addr_nxt;
      active_root_r <= active_root_nxt;
      active_fault_r <= active_fault_nxt;
      root_pend_r <= root_pend_nxt;
      root_sts_r <= root_sts_nxt;
      fault_pend_r <= fault_pend_nxt;
      fault_sts_r <= fault_sts_nxt;
    end
  end

  // read path, one cycle latency
  always_comb begin
    rdata_nxt = rgc_pkg::WORD_RESET;
    if (REG_RD) begin
      case (REG_ADDR)
        // command word reads as a fixed filler
        rgc_pkg::GLOBAL_COMMAND_OFS: rdata_nxt = rgc_pkg::UNDEFINED_READ;
        rgc_pkg::GLOBAL_STATUS_OFS: begin
          rdata_nxt[rgc_pkg::DMA_REMAP_ON_BIT] = remap_r;
          rdata_nxt[rgc_pkg::LOAD_ROOT_POINTER_BIT] = root_sts_r;
          rdata_nxt[rgc_pkg::LOAD_FAULT_LOG_POINTER_BIT] = fault_sts_r;
        end
        rgc_pkg::ROOT_TABLE_ADDRESS_OFS: rdata_nxt = root_addr_r;
        rgc_pkg::FAULT_LOG_ADDRESS_OFS: rdata_nxt = fault_addr_r;
        rgc_pkg::ACTIVE_ROOT_OFS: rdata_nxt = active_root_r;
        rgc_pkg::ACTIVE_FAULT_OFS: rdata_nxt = active_fault_r;
        default: rdata_nxt = rgc_pkg::WORD_RESET;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      rdata_r <= rgc_pkg::WORD_RESET;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign REG_RDATA = rdata_r;
  assign DMA_HOLD = hold_r;
  assign REMAP_ACTIVE = remap_r;
  assign ROOT_POINTER = active_root_r;
  assign FAULT_LOG_POINTER = active_fault_r;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);

  sequence root_cmd_s;
    wr_cmd && REG_WDATA[rgc_pkg::LOAD_ROOT_POINTER_BIT];
  endsequence

  sequence fault_cmd_s;
    wr_cmd && REG_WDATA[rgc_pkg::LOAD_FAULT_LOG_POINTER_BIT] && ADV_LOG_EN == 1;
  endsequence

  mode_latch_a: assert property (
    wr_cmd |=> target_r == $past(REG_WDATA[rgc_pkg::DMA_REMAP_ON_BIT]))
    else $error("requested mode not latched");

  remap_status_a: assert property (
    $changed(remap_r) |-> $past(state_r) == rgc_pkg::ST_DRAIN && state_r == rgc_pkg::ST_IDLE)
    else $error("remap status changed outside a completed switch");

  switch_boundary_a: assert property (
    $changed(REMAP_ACTIVE) |-> $past(drain_idle) && REMAP_ACTIVE == $past(target_r))
    else $error("remap switched with transactions in flight");

  drain_hold_a: assert property (
    state_r == rgc_pkg::ST_DRAIN |-> DMA_HOLD == (DRAIN_EN == 1))
    else $error("new requests not held while draining");

  cmd_read_a: assert property (
    REG_RD && REG_ADDR == rgc_pkg::GLOBAL_COMMAND_OFS |=> REG_RDATA == rgc_pkg::UNDEFINED_READ)
    else $error("command word read returned live state");

  root_load_a: assert property (
    root_cmd_s ##1 !(wr_cmd && REG_WDATA[rgc_pkg::LOAD_ROOT_POINTER_BIT])
    |=> ROOT_POINTER == $past(root_addr_r))
    else $error("root pointer not taken from address register");

  root_status_a: assert property (
    $rose(root_sts_r) |-> $past(root_pend_r) && ROOT_POINTER == $past(root_addr_r))
    else $error("root status set before pointer load");

  zero_write_a: assert property (
    wr_cmd && !REG_WDATA[rgc_pkg::LOAD_ROOT_POINTER_BIT] && !root_pend_r |=> !root_pend_r && $stable(ROOT_POINTER))
    else $error("zero load bit caused an action");

  fault_load_a: assert property (
    fault_cmd_s ##1 !(wr_cmd && REG_WDATA[rgc_pkg::LOAD_FAULT_LOG_POINTER_BIT] && ADV_LOG_EN == 1)
    |=> FAULT_LOG_POINTER == $past(fault_addr_r) && fault_sts_r)
    else $error("fault-log pointer not loaded");

  fault_status_a: assert property (
    $rose(fault_sts_r) |-> $past(fault_pend_r))
    else $error("fault status set before pointer load");

  live_reload_a: assert property (
    (REMAP_ACTIVE and fault_cmd_s) |=> fault_pend_r && !fault_sts_r)
    else $error("fault pointer reload refused while remapping");

  cmd_trigger_a: assert property (
    root_cmd_s |=> !root_sts_r ##1 (root_sts_r || root_pend_r))
    else $error("root load status not cleared then set");

  // a mode change asked for while nothing else is pending
  sequence switch_req_s;
    wr_cmd && state_r == rgc_pkg::ST_IDLE && target_r == remap_r
    && REG_WDATA[rgc_pkg::DMA_REMAP_ON_BIT] != remap_r;
  endsequence

  switch_start_a: assert property (
    switch_req_s |-> ##2 state_r == rgc_pkg::ST_DRAIN && DMA_HOLD == (DRAIN_EN == 1))
    else $error("remap request did not start a drain");

  hold_release_a: assert property (
    $fell(DMA_HOLD) |-> $past(drain_idle) && state_r == rgc_pkg::ST_IDLE)
    else $error("hold released before the drain finished");

  fault_zero_a: assert property (
    wr_cmd && !REG_WDATA[rgc_pkg::LOAD_FAULT_LOG_POINTER_BIT] && !fault_pend_r
    |=> !fault_pend_r && $stable(FAULT_LOG_POINTER))
    else $error("zero fault load bit caused an action");
endmodule

/* dv/rgc_top_tb_top.sv */
`timescale 1ns/10ps
module rgc_top_tb_top;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic dma_start = 1'b0;
  logic dma_done = 1'b0;
  logic dma_hold;
  logic remap_active;
  logic [31:0] root_pointer;
  logic [31:0] fault_log_pointer;
  int num_errors = 0;
  int checks_done = 0;

  rgc_top #(.DRAIN_EN(1), .ADV_LOG_EN(1), .CNT_W(6)) dut (
    .CLOCK(clock), .RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .DMA_START(dma_start),
    .DMA_DONE(dma_done), .DMA_HOLD(dma_hold), .REMAP_ACTIVE(remap_active),
    .ROOT_POINTER(root_pointer), .FAULT_LOG_POINTER(fault_log_pointer)
  );

  initial begin
    forever #2 clock = ~clock;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // write strobe taken at the second edge; returns just after it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic dma_pulse(input logic s, input logic e);
    @(posedge clock);
    dma_start <= s;
    dma_done <= e;
    @(posedge clock);
    dma_start <= 1'b0;
    dma_done <= 1'b0;
    #1;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic t_reset_state();
    logic [31:0] d;
    chk(remap_active, 32'h0, "remap after reset");
    chk(root_pointer, 32'h0, "root after reset");
    chk(dma_hold, 32'h0, "hold after reset");
    chk(fault_log_pointer, 32'h0, "fault after reset");
    rd(rgc_pkg::GLOBAL_STATUS_OFS, d);
    chk(d, 32'h0000_0000, "status after reset");
    wr(rgc_pkg::GLOBAL_COMMAND_OFS, 32'h4000_0000);
    rd(rgc_pkg::GLOBAL_COMMAND_OFS, d);
    chk(d, rgc_pkg::UNDEFINED_READ, "command read");
    cycles(1);
    chk(reg_rdata, 32'h0000_0000, "read data one cycle only");
    rd(8'h44, d);
    chk(d, 32'h0000_0000, "unmapped read");
  endtask

  task automatic t_root_load();
    logic [31:0] d;
    wr(rgc_pkg::ROOT_TABLE_ADDRESS_OFS, 32'h1234_5000);
    wr(rgc_pkg::GLOBAL_COMMAND_OFS, 32'h4000_0000);
    chk(root_pointer, 32'h0000_0000, "root before completion");
    cycles(2);
    chk(root_pointer, 32'h1234_5000, "root latched");
    rd(rgc_pkg::GLOBAL_STATUS_OFS, d);
    chk(d & 32'he000_0000, 32'h4000_0000, "root status");
    rd(rgc_pkg::ACTIVE_ROOT_OFS, d);
    chk(d, 32'h1234_5000, "active root read");
  endtask

  task automatic t_zero_load();
    wr(rgc_pkg::ROOT_TABLE_ADDRESS_OFS, 32'h0bad_0000);
    wr(rgc_pkg::FAULT_LOG_ADDRESS_OFS, 32'h0bad_1000);
    wr(rgc_pkg::GLOBAL_COMMAND_OFS, 32'h0000_0000);
    cycles(4);
    chk(root_pointer, 32'h1234_5000, "root kept on zero");
    chk(fault_log_pointer, 32'h0000_0000, "fault kept on zero");
    chk(remap_active, 32'h0, "no switch on same mode");
  endtask

  task automatic t_remap_on_drain();
    logic [31:0] d;
    int i;
    dma_pulse(1'b1, 1'b0);
    wr(rgc_pkg::GLOBAL_COMMAND_OFS, 32'h8000_0000);
    cycles(4);
    chk(dma_hold, 32'h1, "hold while draining");
    chk(remap_active, 32'h0, "no switch while in flight");
    rd(rgc_pkg::GLOBAL_STATUS_OFS, d);
    chk(d & 32'h8000_0000, 32'h0, "status before drain");
    dma_pulse(1'b0, 1'b1);
    for (i = 0; i < 10 && remap_active !== 1'b1; i++) begin
      cycles(1);
    end
    chk(remap_active, 32'h1, "remap on after drain");
    chk(dma_hold, 32'h0, "hold released");
    rd(rgc_pkg::GLOBAL_STATUS_OFS, d);
    chk(d & 32'h8000_0000, 32'h8000_0000, "remap status on");
  endtask

  task automatic t_fault_reload();
    logic [31:0] d;
    wr(rgc_pkg::FAULT_LOG_ADDRESS_OFS, 32'h00f0_0000);
    // one field per write, bit 31 kept on
    wr(rgc_pkg::GLOBAL_COMMAND_OFS, 32'ha000_0000);
    cycles(2);
    chk(fault_log_pointer, 32'h00f0_0000, "fault pointer latched");
    rd(rgc_pkg::GLOBAL_STATUS_OFS, d);
    chk(d & 32'ha000_0000, 32'ha000_0000, "fault status, remap kept");
    chk(remap_active, 32'h1, "remap stays on");
    rd(rgc_pkg::ACTIVE_FAULT_OFS, d);
    chk(d, 32'h00f0_0000, "active fault read");
    // live reload onto a copy of the tables
    wr(rgc_pkg::ROOT_TABLE_ADDRESS_OFS, 32'h1234_6000);
    wr(rgc_pkg::GLOBAL_COMMAND_OFS, 32'hc000_0000);
    cycles(2);
    chk(root_pointer, 32'h1234_6000, "live root reload");
    chk(remap_active, 32'h1, "remap kept over reload");
  endtask

  task automatic t_remap_off();
    logic [31:0] d;
    int i;
    wr(rgc_pkg::GLOBAL_COMMAND_OFS, 32'h0000_0000);
    for (i = 0; i < 10 && remap_active !== 1'b0; i++) begin
      cycles(1);
    end
    chk(remap_active, 32'h0, "remap off");
    chk(dma_hold, 32'h0, "hold released after off");
    rd(rgc_pkg::GLOBAL_STATUS_OFS, d);
    chk(d & 32'h8000_0000, 32'h0, "remap status off");
  endtask

  initial begin
    #200000;
    num_errors++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    cycles(2);
    t_reset_state();
    // root load precedes the first enable
    t_root_load();
    t_zero_load();
    t_remap_on_drain();
    t_fault_reload();
    t_remap_off();
    cycles(4);
    test_done();
  end
endmodule
